// *** tuning_defs.svh ***
// Constants for the channel tuning controller: timing, layouts, limits.
// Assumes a 40 MHz system clock; included by the package and the design.
`ifndef TUNING_DEFS_SVH
`define TUNING_DEFS_SVH

// ==========================================================
// Clock and times
`define CLK_MHZ          40
`define MEM_PERIOD_US    512
`define MUX_PERIOD_MS    16
`define REPEAT_MS        250
`define KEY_RPT_MS       250
`define US_PER_MS        1000
`define MEM_PERIOD_CYC   (`MEM_PERIOD_US * `CLK_MHZ)
`define MUX_PERIOD_CYC   (`MUX_PERIOD_MS * `US_PER_MS * `CLK_MHZ)
`define REPEAT_CYC       (`REPEAT_MS * `US_PER_MS * `CLK_MHZ)
`define KEY_RPT_CYC      (`KEY_RPT_MS * `US_PER_MS * `CLK_MHZ)

// ==========================================================
// Memory word: 14 bits, least significant first
`define MEM_BITS         14
`define MW_UNITS_LSB     0
`define MW_TENS_LSB      4
`define MW_FINE_LSB      8

// ==========================================================
// Divider word and fine tuning
`define DIV_BITS         13
`define ADD_BITS         6
`define BAND_BITS        3
`define FINE_MID         6'h20
`define FINE_MAX         6'h3f
`define FINE_MIN         6'h00
`define FIFO_DEPTH       4
`define DIGIT_MAX        4'h9
`define BCD_LIMIT        4'hf

`endif

// *** tuning_pkg.sv ***
// Types shared by the tuning controller and its buffer.
// Assumes tuning_defs.svh is on the include path.
`include "tuning_defs.svh"

package tuning_pkg;

	// Sequencer states, one-hot
	typedef enum logic [8:0] {
		st_idle    = 9'h001,
		st_rd_wait = 9'h002,
		st_rd_clk  = 9'h004,
		st_prep    = 9'h008,
		st_sync    = 9'h010,
		st_shift   = 9'h020,
		st_st_wait = 9'h040,
		st_st_clk  = 9'h080,
		st_st_hold = 9'h100
	} seq_state_type;

	// Two decimal digits of the channel counter
	typedef struct packed {
		logic [3:0] tens;
		logic [3:0] units;
	} channel_type;

	// Channel table entry: band bits {uhf, vhf, three} and divider base
	typedef struct packed {
		logic [`BAND_BITS-1:0] band;
		logic [`DIV_BITS-1:0]  factor;
	} rom_word_type;

endpackage

// *** tuning_controller.sv ***
// Channel tuning controller with its divider-word buffer.
// Assumes one 40 MHz clock; all inputs synchronous to it, keys active high.
//
// What this block does
// - Program change on request or power-on edge
// - Read-in: select low, wait, 14 memory clocks
// - Sample memory bits on memory clock rise
// - After read-in, select high, data line released
// - Channel number addresses ROM, loads shift register
// - Load enable high, 13 bits, then drop
// - Serial adder adds fine offset, low bits
// - Repeat divider transfer every 250 ms
// - Ignore keys except search stop, and program change requests, while busy; power-on edge held pending
// - Fine offset +31 / -32 steps
// - Channel change recentres fine counter
// - Fine keys step by one, auto-repeat
// - Tens and units keys, no carry, no repeat
// - Search steps units with carry until stop
// - Store: wait, then 14 memory clocks
// - Store advances data bit each clock rise
// - After store and request low, verify run
// - Storage blocks change and tuning keys
// - Decimal channel, multiplexed BCD, 16 ms period
// - Limit shown while fine key held
// - Band outputs change only at load enable rise
// - Divider sent least significant bit first
// - Load enable high only while sync low

`include "tuning_defs.svh"

// ==========================================================
// Word buffer
module word_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 4
) (
	// Clock and reset
	input  logic             clk,
	input  logic             sys_rst,
	// Filling side
	input  logic             in_valid,
	output logic             in_ready,
	input  logic [WIDTH-1:0] in_data,
	// Draining side
	output logic             out_valid,
	input  logic             out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW:0]      wr_ptr_q;
	logic [AW:0]      rd_ptr_q;

	// Full when pointers differ only in the wrap bit
	assign in_ready  = !((wr_ptr_q[AW] != rd_ptr_q[AW]) && (wr_ptr_q[AW-1:0] == rd_ptr_q[AW-1:0]));
	assign out_valid = (wr_ptr_q != rd_ptr_q);
	assign out_data  = mem_q[rd_ptr_q[AW-1:0]];

	// Storage
	always_ff @(posedge clk) begin
		if (in_valid && in_ready) begin
			mem_q[wr_ptr_q[AW-1:0]] <= in_data;
		end
	end

	// Pointers
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
		end else begin
			if (in_valid && in_ready) wr_ptr_q <= wr_ptr_q + 1'b1;
			if (out_valid && out_ready) rd_ptr_q <= rd_ptr_q + 1'b1;
		end
	end
endmodule // word_fifo

// ==========================================================
// Tuning controller
module tuning_controller import tuning_pkg::*; #(
	parameter int MEM_PERIOD_CYC = `MEM_PERIOD_CYC,
	parameter int MUX_PERIOD_CYC = `MUX_PERIOD_CYC,
	parameter int REPEAT_CYC     = `REPEAT_CYC,
	parameter int KEY_RPT_CYC    = `KEY_RPT_CYC
) (
	// Clock and reset
	input  logic       clk,
	input  logic       sys_rst,
	// Requests
	input  logic       program_change_request,
	input  logic       power_on_trigger,
	input  logic       memory_store_request,
	// Front-panel keys
	input  logic       fine_up_key,
	input  logic       fine_down_key,
	input  logic       tens_key,
	input  logic       units_key,
	input  logic       search_start_key,
	input  logic       search_stop_key,
	// Tuning memory
	output logic       memory_shift_clock,
	output logic       memory_read_select,
	input  logic       memory_data_line_in,
	output logic       memory_data_line_out,
	output logic       memory_data_line_oe,
	// PLL divider
	input  logic       shift_timing_in,
	input  logic       frame_sync_in,
	output logic       pll_serial_data,
	output logic       pll_load_enable,
	// Display
	output logic [3:0] bcd_digit,
	output logic       digit_select_one,
	output logic       digit_select_two,
	// Band selection
	output logic       band_select_uhf,
	output logic       band_select_vhf,
	output logic       band_select_three
);
	localparam int MW = $clog2(MEM_PERIOD_CYC + 1);
	localparam int XW = $clog2(MUX_PERIOD_CYC + 1);
	localparam int RW = $clog2(REPEAT_CYC + 1);
	localparam int KW = $clog2(KEY_RPT_CYC + 1);
	localparam logic [MW-1:0] MEM_LAST  = MW'(MEM_PERIOD_CYC); // Full period before first rise
	localparam logic [MW-1:0] MEM_HALF  = MW'(MEM_PERIOD_CYC / 2 - 1);
	localparam logic [XW-1:0] MUX_LAST  = XW'(MUX_PERIOD_CYC - 1);
	localparam logic [XW-1:0] MUX_HALF  = XW'(MUX_PERIOD_CYC / 2);
	localparam logic [XW-1:0] MUX_GAP   = XW'(MUX_PERIOD_CYC / 16);
	localparam logic [RW-1:0] RPT_LAST  = RW'(REPEAT_CYC - 1);
	localparam logic [KW-1:0] KEY_LAST  = KW'(KEY_RPT_CYC - 1);
	localparam logic [4:0]    MEM_CNT   = 5'(`MEM_BITS);
	localparam logic [3:0]    DIV_CNT   = 4'(`DIV_BITS);

	// Channel table lookup: divider base and band bits per channel
	function automatic rom_word_type rom_lookup(input channel_type ch);
		rom_word_type w;
		int n;
		n = int'(ch.tens) * 10 + int'(ch.units);
		w.band = 3'b101;
		w.factor = '0;
		if (n >= 21 && n <= 73) begin
			w.factor = 13'(4081 + 64 * (n - 21));
			w.band = 3'b110;
		end else if (n >= 5 && n <= 12) begin
			w.factor = 13'(1713 + 56 * (n - 5));
			w.band = 3'b001;
		end else if (n >= 81 && n <= 90) begin
			w.factor = 13'(1153 + 56 * (n - 81));
			w.band = 3'b001;
		end else if (n >= 91 || n == 0) begin
			w.factor = 13'(2161 + 56 * ((n == 0) ? 9 : (n - 91)));
			w.band = 3'b001;
		end else begin
			case (n)
				1: w.factor = 13'd681;
				2: w.factor = 13'd697;
				3: w.factor = 13'd753;
				4: w.factor = 13'd809;
				13: w.factor = 13'd741;
				14: w.factor = 13'd809;
				15: w.factor = 13'd969;
				74: w.factor = 13'd865;
				75: w.factor = 13'd921;
				76: w.factor = 13'd977;
				77: w.factor = 13'd1033;
				78: w.factor = 13'd1089;
				79: w.factor = 13'd785;
				80: w.factor = 13'd1057;
				19, 20: begin
					w.factor = (n == 19) ? 13'd1921 : 13'd1993;
					w.band = 3'b001;
				end
				default: begin
					w.factor = 13'(1713 + 68 * (n - 16));
					w.band = 3'b001;
				end
			endcase
		end
		return w;
	endfunction

	seq_state_type        state_q;
	channel_type          channel_q;
	logic [5:0]           fine_q;
	logic [MW-1:0]        mem_tmr_q;
	logic [4:0]           mem_cnt_q;
	logic [`MEM_BITS-1:0] rd_sreg_q;
	logic [`MEM_BITS-1:0] st_sreg_q;
	logic [`DIV_BITS-1:0] div_sreg_q;
	logic [5:0]           offset_q;
	logic [3:0]           bit_idx_q;
	logic [3:0]           rise_cnt_q;
	logic                 carry_q;
	logic                 mclk_q, rsel_q, mdat_q, moe_q, pdat_q, ple_q;
	logic [2:0]           band_q;
	logic [RW-1:0]        rpt_tmr_q;
	logic                 rpt_pend_q, por_pend_q;
	logic [KW-1:0]        key_tmr_q;
	logic                 search_q, limit_q;
	logic [XW-1:0]        mux_tmr_q;
	logic [3:0]           bcd_q;
	logic                 ds1_q, ds2_q;
	logic                 pc_prev_q, por_prev_q, cl_prev_q, sync_prev_q;
	logic                 up_prev_q, dn_prev_q, tn_prev_q, un_prev_q, ss_prev_q;
	logic                 fifo_in_ready, fifo_out_valid, pop;
	rom_word_type         fifo_out;
	logic                 idle, key_tick, mem_half_end, read_done;
	logic                 cl_rise, cl_fall, sync_fall;
	logic                 tens_go, units_go, search_go, chan_step;
	logic                 up_go, dn_go, add_b, sum_b, carry_d;

	// Edge detectors and gating of the front panel
	assign idle      = (state_q == st_idle);
	assign cl_rise   = shift_timing_in && !cl_prev_q;
	assign cl_fall   = !shift_timing_in && cl_prev_q;
	assign sync_fall = !frame_sync_in && sync_prev_q;
	assign key_tick  = (key_tmr_q == KEY_LAST);
	assign tens_go   = idle && tens_key && !tn_prev_q;
	assign units_go  = idle && units_key && !un_prev_q;
	assign search_go = idle && search_q && key_tick && !search_stop_key;
	assign chan_step = tens_go || units_go || search_go;
	assign up_go     = idle && fine_up_key && (!up_prev_q || key_tick);
	assign dn_go     = idle && fine_down_key && !fine_up_key && (!dn_prev_q || key_tick);
	assign mem_half_end = (mem_tmr_q == MEM_HALF);
	assign read_done = (state_q == st_rd_clk) && mem_half_end && mclk_q && (mem_cnt_q == MEM_CNT);
	assign pop       = (state_q == st_sync) && sync_fall && fifo_out_valid;

	// Serial adder: offset bits, then sign extension for the upper bits
	assign add_b   = (bit_idx_q < 4'(`ADD_BITS)) ? offset_q[bit_idx_q[2:0]] : offset_q[5];
	assign sum_b   = div_sreg_q[0] ^ add_b ^ carry_q;
	assign carry_d = (div_sreg_q[0] & add_b) | (carry_q & (div_sreg_q[0] ^ add_b));

	// Input history
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			{pc_prev_q, por_prev_q, cl_prev_q, sync_prev_q} <= 4'h0;
			{up_prev_q, dn_prev_q, tn_prev_q, un_prev_q, ss_prev_q} <= 5'h00;
		end else begin
			{pc_prev_q, por_prev_q} <= {program_change_request, power_on_trigger};
			{cl_prev_q, sync_prev_q} <= {shift_timing_in, frame_sync_in};
			{up_prev_q, dn_prev_q} <= {fine_up_key, fine_down_key};
			{tn_prev_q, un_prev_q, ss_prev_q} <= {tens_key, units_key, search_start_key};
		end
	end

	// Pending power-on and repeat requests; a new event beats the clear
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rpt_tmr_q <= '0;
			rpt_pend_q <= 1'b0;
			por_pend_q <= 1'b0;
		end else begin
			rpt_tmr_q <= (rpt_tmr_q == RPT_LAST) ? '0 : rpt_tmr_q + 1'b1;
			if (rpt_tmr_q == RPT_LAST) rpt_pend_q <= 1'b1;
			else if (idle) rpt_pend_q <= 1'b0;
			if (power_on_trigger != por_prev_q) por_pend_q <= 1'b1;
			else if (idle) por_pend_q <= 1'b0;
		end
	end

	// Main sequencer
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state_q <= st_idle;
		end else begin
			case (state_q)
				st_idle: begin
					if (memory_store_request) state_q <= st_st_wait;
					else if ((program_change_request && !pc_prev_q) || por_pend_q)
						state_q <= st_rd_wait;
					else if (rpt_pend_q) state_q <= st_prep;
				end
				st_rd_wait: if (mem_tmr_q == MEM_LAST) state_q <= st_rd_clk;
				st_rd_clk: if (read_done) state_q <= st_prep;
				st_prep: if (fifo_in_ready) state_q <= st_sync;
				st_sync: if (pop) state_q <= st_shift;
				st_shift: if (cl_rise && rise_cnt_q == DIV_CNT - 4'd1) state_q <= st_idle;
				st_st_wait: if (mem_tmr_q == MEM_LAST) state_q <= st_st_clk;
				st_st_clk: begin
					if (mem_half_end && mclk_q && mem_cnt_q == MEM_CNT) state_q <= st_st_hold;
				end
				st_st_hold: if (!memory_store_request) state_q <= st_rd_wait;
				default: state_q <= st_idle;
			endcase
		end
	end

	// Memory clock, select and data stage
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			mem_tmr_q <= '0;
			mem_cnt_q <= '0;
			{mclk_q, mdat_q, moe_q} <= 3'b000;
			rsel_q <= 1'b1;
			rd_sreg_q <= '0;
			st_sreg_q <= '0;
		end else begin
			rsel_q <= !(state_q inside {st_rd_wait, st_rd_clk}) || read_done;
			moe_q <= (state_q inside {st_st_wait, st_st_clk});
			if (state_q inside {st_rd_wait, st_st_wait}) begin
				mem_cnt_q <= '0;
				mem_tmr_q <= (mem_tmr_q == MEM_LAST) ? '0 : mem_tmr_q + 1'b1;
				if (mem_tmr_q == MEM_LAST) begin
					mclk_q <= 1'b1;
					mem_cnt_q <= 5'd1;
					if (state_q == st_rd_wait) rd_sreg_q <= {memory_data_line_in, rd_sreg_q[`MEM_BITS-1:1]};
					else {st_sreg_q, mdat_q} <= {1'b0, st_sreg_q};
				end
			end else if (state_q inside {st_rd_clk, st_st_clk}) begin
				mem_tmr_q <= mem_half_end ? '0 : mem_tmr_q + 1'b1;
				if (mem_half_end) begin
					mclk_q <= !mclk_q;
					if (!mclk_q) begin
						mem_cnt_q <= mem_cnt_q + 5'd1;
						if (state_q == st_rd_clk)
							rd_sreg_q <= {memory_data_line_in, rd_sreg_q[`MEM_BITS-1:1]};
						else {st_sreg_q, mdat_q} <= {1'b0, st_sreg_q};
					end
				end
			end else begin
				mem_tmr_q <= '0;
				mclk_q <= 1'b0;
				mdat_q <= 1'b0;
				st_sreg_q <= {fine_q, channel_q.tens, channel_q.units};
			end
		end
	end

	// Divider transfer to the PLL
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			{pdat_q, ple_q, carry_q} <= 3'b000;
			band_q <= '0;
			div_sreg_q <= '0;
			offset_q <= '0;
			bit_idx_q <= '0;
			rise_cnt_q <= '0;
		end else if (pop) begin
			ple_q <= 1'b1;
			band_q <= fifo_out.band;
			offset_q <= fine_q ^ `FINE_MID;
			div_sreg_q <= fifo_out.factor;
			bit_idx_q <= '0;
			rise_cnt_q <= '0;
			carry_q <= 1'b0;
		end else if (state_q == st_shift) begin
			if (bit_idx_q == '0 || (cl_fall && bit_idx_q < DIV_CNT && bit_idx_q == rise_cnt_q)) begin
				pdat_q <= sum_b;
				carry_q <= carry_d;
				div_sreg_q <= {1'b0, div_sreg_q[`DIV_BITS-1:1]};
				bit_idx_q <= bit_idx_q + 4'd1;
			end
			if (cl_rise) begin
				rise_cnt_q <= rise_cnt_q + 4'd1;
				if (rise_cnt_q == DIV_CNT - 4'd1) ple_q <= 1'b0;
			end
		end else begin
			ple_q <= 1'b0;
			pdat_q <= 1'b0;
		end
	end

	// Channel counter in two decimal digits
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			channel_q <= '0;
		end else if (read_done) begin
			channel_q.units <= rd_sreg_q[`MW_UNITS_LSB +: 4];
			channel_q.tens <= rd_sreg_q[`MW_TENS_LSB +: 4];
		end else if (tens_go) begin
			channel_q.tens <= (channel_q.tens >= `DIGIT_MAX) ? 4'h0 : channel_q.tens + 4'h1;
		end else if (units_go || search_go) begin
			channel_q.units <= (channel_q.units >= `DIGIT_MAX) ? 4'h0 : channel_q.units + 4'h1;
			if (search_go && channel_q.units >= `DIGIT_MAX)
				channel_q.tens <= (channel_q.tens >= `DIGIT_MAX) ? 4'h0 : channel_q.tens + 4'h1;
		end
	end

	// Fine detuning counter with limits and limit indication
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			fine_q <= `FINE_MID;
			limit_q <= 1'b0;
		end else begin
			limit_q <= idle && ((fine_up_key && fine_q == `FINE_MAX) ||
				(fine_down_key && fine_q == `FINE_MIN));
			if (read_done) fine_q <= rd_sreg_q[`MW_FINE_LSB +: 6];
			else if (chan_step) fine_q <= `FINE_MID;
			else if (up_go && fine_q != `FINE_MAX) fine_q <= fine_q + 6'h01;
			else if (dn_go && fine_q != `FINE_MIN) fine_q <= fine_q - 6'h01;
		end
	end

	// Auto-repeat timer and search mode
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			key_tmr_q <= '0;
			search_q <= 1'b0;
		end else begin
			if (search_stop_key) search_q <= 1'b0;
			else if (idle && search_start_key && !ss_prev_q) search_q <= 1'b1;
			if ((up_go || dn_go) && !key_tick) key_tmr_q <= '0;
			else if (fine_up_key || fine_down_key || search_q)
				key_tmr_q <= key_tick ? '0 : key_tmr_q + 1'b1;
			else key_tmr_q <= '0;
		end
	end

	// Display multiplex with a blank gap after each digit change
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			mux_tmr_q <= '0;
			bcd_q <= '0;
			{ds1_q, ds2_q} <= 2'b00;
		end else begin
			mux_tmr_q <= (mux_tmr_q == MUX_LAST) ? '0 : mux_tmr_q + 1'b1;
			bcd_q <= limit_q ? `BCD_LIMIT :
				(mux_tmr_q < MUX_HALF) ? channel_q.units : channel_q.tens;
			ds1_q <= (mux_tmr_q >= MUX_GAP) && (mux_tmr_q < MUX_HALF);
			ds2_q <= (mux_tmr_q >= MUX_HALF + MUX_GAP);
		end
	end

	word_fifo #(
		.WIDTH($bits(rom_word_type)),
		.DEPTH(`FIFO_DEPTH)
	) u_fifo (
		.clk(clk),
		.sys_rst(sys_rst),
		.in_valid(state_q == st_prep),
		.in_ready(fifo_in_ready),
		.in_data(rom_lookup(channel_q)),
		.out_valid(fifo_out_valid),
		.out_ready(pop),
		.out_data(fifo_out)
	);

	// Outputs straight from flip-flops
	assign memory_shift_clock   = mclk_q;
	assign memory_read_select   = rsel_q;
	assign memory_data_line_out = mdat_q;
	assign memory_data_line_oe  = moe_q;
	assign pll_serial_data      = pdat_q;
	assign pll_load_enable      = ple_q;
	assign {band_select_uhf, band_select_vhf, band_select_three} = band_q;
	assign bcd_digit            = bcd_q;
	assign digit_select_one     = ds1_q;
	assign digit_select_two     = ds2_q;

	// Checks: clock rises seen per load enable window
	logic [3:0] chk_rises_q;
	always_ff @(posedge clk) begin
		if (sys_rst || !ple_q) chk_rises_q <= '0;
		else if (cl_rise) chk_rises_q <= chk_rises_q + 4'd1;
	end

	a_ple_sync_low: assert property (@(posedge clk) disable iff (sys_rst)
		$rose(ple_q) |-> !$past(frame_sync_in) && $past(sync_prev_q))
		else $error("load enable raised while sync high");
	a_ple_thirteen: assert property (@(posedge clk) disable iff (sys_rst)
		$fell(ple_q) |-> chk_rises_q == 4'd13)
		else $error("load enable dropped after wrong clock count");
	a_band_at_rise: assert property (@(posedge clk) disable iff (sys_rst)
		$changed(band_q) |-> $rose(ple_q))
		else $error("band changed outside load enable rise");
	a_read_released: assert property (@(posedge clk) disable iff (sys_rst)
		!rsel_q |-> !moe_q)
		else $error("data line driven during read");
	a_store_select: assert property (@(posedge clk) disable iff (sys_rst)
		$rose(state_q == st_st_clk) |-> rsel_q && moe_q && mclk_q)
		else $error("store clock phase wrong");
	a_fine_recentre: assert property (@(posedge clk) disable iff (sys_rst)
		chan_step |=> fine_q == `FINE_MID)
		else $error("fine counter not recentred");
	a_fine_ceiling: assert property (@(posedge clk) disable iff (sys_rst)
		fine_q == `FINE_MAX && !read_done && !chan_step |=> fine_q == `FINE_MAX)
		else $error("fine counter passed its upper limit");
	a_busy_hold: assert property (@(posedge clk) disable iff (sys_rst)
		state_q == st_shift |=> $stable(channel_q) && $stable(fine_q))
		else $error("channel altered during transfer");
	a_digit_excl: assert property (@(posedge clk) disable iff (sys_rst)
		!(ds1_q && ds2_q))
		else $error("both digits selected");
	a_verify_after: assert property (@(posedge clk) disable iff (sys_rst)
		state_q == st_st_hold && !memory_store_request |=> state_q == st_rd_wait ##1 !rsel_q)
		else $error("no verify read after store");
endmodule // tuning_controller

// *** tuning_partner.sv ***
// Far-side model: PLL divider with its frame timing, and the tuning memory.
// Assumes the controller's 40 MHz clock and synchronous active-high reset.
// ==========================================================
// PLL divider and serial tuning memory
module tuning_partner (
	// Clock and reset
	input  logic        clk,
	input  logic        sys_rst,
	// Memory side
	input  logic        memory_shift_clock,
	input  logic        memory_read_select,
	input  logic        memory_data_line_out,
	input  logic        memory_data_line_oe,
	output logic        memory_data_line_in,
	input  logic [13:0] load_word,
	input  logic        load_strobe,
	output logic [13:0] mem_word,
	output logic [4:0]  phase_count,
	// PLL side
	input  logic        pll_serial_data,
	input  logic        pll_load_enable,
	output logic        shift_timing_in,
	output logic        frame_sync_in,
	output logic [12:0] pll_word,
	output logic [7:0]  pll_count
);
	logic [7:0] frame;
	logic [3:0] bit_idx;
	logic       cl_q, en_q, mclk_q, last_q;

	// Frame: sync high 4 cycles, then 13 shift clocks while sync low
	always_ff @(posedge clk) begin
		frame <= (sys_rst || frame == 8'd139) ? 8'd0 : frame + 8'd1;
	end
	assign frame_sync_in   = frame < 8'd4;
	assign shift_timing_in = frame >= 8'd24 && frame < 8'd124 && !frame[2];

	// Divider takes a bit per shift clock rise, keeps the last 13
	always_ff @(posedge clk) begin
		cl_q <= shift_timing_in;
		en_q <= pll_load_enable;
		if (shift_timing_in && !cl_q && pll_load_enable) begin
			pll_word <= {pll_serial_data, pll_word[12:1]};
		end
		if (sys_rst) begin
			pll_count <= 8'h00;
		end else if (en_q && !pll_load_enable) begin
			pll_count <= pll_count + 8'h01;
		end
	end

	// Memory: bit presented before each rise, stored bits taken on fall
	always_ff @(posedge clk) begin
		mclk_q <= memory_shift_clock;
		last_q <= sys_rst ? 1'b0 : memory_data_line_in;
		if (load_strobe) begin
			mem_word <= load_word;
		end else if (mclk_q && !memory_shift_clock && memory_data_line_oe) begin
			mem_word <= {memory_data_line_out, mem_word[13:1]};
		end
		if (load_strobe) begin
			phase_count <= 5'h00;
		end else if (memory_shift_clock && !mclk_q) begin
			phase_count <= phase_count + 5'h01;
		end
		if (memory_read_select) begin
			bit_idx <= 4'h0;
		end else if (mclk_q && !memory_shift_clock) begin
			bit_idx <= bit_idx + 4'h1;
		end
	end

	// Wire level; a released line keeps changing rather than holding
	assign memory_data_line_in = memory_data_line_oe ? memory_data_line_out
		: (!memory_read_select ? mem_word[bit_idx] : ~last_q);
endmodule // tuning_partner

// *** tuning_controller_test.sv ***
// Self-checking bench for the channel tuning controller.
// Assumes tuning_pkg, tuning_controller and tuning_partner are compiled first.
// ==========================================================
// Test top
module tuning_controller_test;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk = 1'b0, sys_rst = 1'b1, load_strobe = 1'b0;
	logic program_change_request = 1'b0, power_on_trigger = 1'b0;
	logic memory_store_request = 1'b0, fine_up_key = 1'b0, fine_down_key = 1'b0;
	logic tens_key = 1'b0, units_key = 1'b0, search_start_key = 1'b0, search_stop_key = 1'b0;
	logic memory_shift_clock, memory_read_select, memory_data_line_in;
	logic memory_data_line_out, memory_data_line_oe, shift_timing_in, frame_sync_in;
	logic pll_serial_data, pll_load_enable, digit_select_one, digit_select_two;
	logic band_select_uhf, band_select_vhf, band_select_three;
	logic [3:0]  bcd_digit;
	logic [13:0] load_word = 14'h0000;
	logic [13:0] mem_word;
	logic [4:0]  phase_count;
	logic [12:0] pll_word;
	logic [7:0]  pll_count;
	int          errors = 0, check_count = 0, cycles = 0;

	tuning_controller #(.MEM_PERIOD_CYC(8), .MUX_PERIOD_CYC(32), .REPEAT_CYC(2000),
		.KEY_RPT_CYC(50)) dut (.clk, .sys_rst, .program_change_request,
		.power_on_trigger, .memory_store_request, .fine_up_key, .fine_down_key,
		.tens_key, .units_key, .search_start_key, .search_stop_key, .memory_shift_clock,
		.memory_read_select, .memory_data_line_in, .memory_data_line_out,
		.memory_data_line_oe, .shift_timing_in, .frame_sync_in, .pll_serial_data,
		.pll_load_enable, .bcd_digit, .digit_select_one, .digit_select_two,
		.band_select_uhf, .band_select_vhf, .band_select_three);
	tuning_partner far (.clk, .sys_rst, .memory_shift_clock, .memory_read_select,
		.memory_data_line_out, .memory_data_line_oe, .memory_data_line_in, .load_word,
		.load_strobe, .mem_word, .phase_count, .pll_serial_data, .pll_load_enable,
		.shift_timing_in, .frame_sync_in, .pll_word, .pll_count);

	// Clock and hang limit
	always #12.5 clk = ~clk;
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			errors++;
			stop_test();
		end
	end

	// ==========================================================
	// Shared tasks
	task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("BAD at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask

	task automatic stop_test();
		$display("Checks %0d, errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// Next complete divider load, then its word and band bits
	task automatic expect_load(input logic [12:0] div, input logic [2:0] band, input int lim);
		logic [7:0] start;
		start = pll_count;
		while (pll_count == start && lim > 0) begin
			@(negedge clk);
			lim--;
		end
		if (pll_count == start) begin
			errors++;
			$display("BAD at %0t: no divider load in time", $time);
		end
		check(pll_word, div, "divider");
		check({band_select_uhf, band_select_vhf, band_select_three}, band, "band");
	endtask

	task automatic press(ref logic key);
		key = 1'b1;
		repeat (3) @(negedge clk);
		key = 1'b0;
	endtask

	task automatic set_memory(input logic [13:0] word);
		load_word = word;
		load_strobe = 1'b1;
		@(negedge clk);
		load_strobe = 1'b0;
	endtask

	// ==========================================================
	// Scenarios
	task automatic read_test(input logic [13:0] word, input logic [12:0] div,
		input logic [2:0] band);
		set_memory(word);
		program_change_request = 1'b1;
		repeat (2) @(negedge clk);
		check(memory_read_select, 1'b0, "select low");
		program_change_request = 1'b0;
		expect_load(div, band, 600);
		check(phase_count, 16'd14, "read clocks");
		check({memory_read_select, memory_data_line_oe}, 2'b10, "released");
	endtask

	task automatic fine_test();
		int seen;
		press(fine_up_key);
		expect_load(13'd742, 3'b101, 2400);
		fine_down_key = 1'b1;
		repeat (2600) @(negedge clk);
		seen = 0;
		repeat (64) begin
			@(negedge clk);
			if (bcd_digit === 4'hf) seen++;
		end
		check(seen > 32, 1'b1, "limit shown");
		fine_down_key = 1'b0;
		repeat (3) @(negedge clk);
		check(bcd_digit === 4'hf, 1'b0, "limit cleared");
		fine_down_key = 1'b0;
		expect_load(13'd709, 3'b101, 2400);
	endtask

	task automatic display_test();
		logic seen1, seen2;
		seen1 = 1'b0;
		seen2 = 1'b0;
		repeat (64) begin
			@(negedge clk);
			if (digit_select_one && bcd_digit === 4'h3) seen1 = 1'b1;
			if (digit_select_two && bcd_digit === 4'h1) seen2 = 1'b1;
		end
		check({seen1, seen2}, 2'b11, "display");
	endtask

	task automatic store_test();
		expect_load(13'd709, 3'b101, 2400);
		set_memory(14'h3fff);
		memory_store_request = 1'b1;
		repeat (20) @(negedge clk);
		check(memory_data_line_oe, 1'b1, "store drive");
		tens_key = 1'b1;
		repeat (200) @(negedge clk);
		check(phase_count, 16'd14, "store clocks");
		check(mem_word, {6'h00, 4'h1, 4'h3}, "stored");
		tens_key = 1'b0;
		memory_store_request = 1'b0;
		repeat (100) if (memory_read_select) @(negedge clk);
		repeat (200) if (!memory_read_select) @(negedge clk);
		check(phase_count, 16'd28, "verify read");
		expect_load(13'd709, 3'b101, 400);
	endtask

	// Search from 13 until the tens digit shows 2, then a power-on read
	task automatic search_test();
		int lim;
		press(search_start_key);
		lim = 1000;
		while (!(digit_select_two && bcd_digit === 4'h2) && lim > 0) begin
			@(negedge clk);
			lim--;
		end
		search_stop_key = 1'b1;
		expect_load(13'd1993, 3'b001, 2400);
		search_stop_key = 1'b0;
		power_on_trigger = 1'b1;
		expect_load(13'd709, 3'b101, 600);
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		repeat (4) @(negedge clk);
		sys_rst = 1'b0;
		read_test({6'd35, 4'h1, 4'h2}, 13'd2108, 3'b001);
		read_test({6'd27, 4'h0, 4'h2}, 13'd692, 3'b101);
		expect_load(13'd692, 3'b101, 2400);
		press(units_key);
		expect_load(13'd753, 3'b101, 2400);
		press(tens_key);
		expect_load(13'd741, 3'b101, 2400);
		display_test();
		fine_test();
		store_test();
		search_test();
		stop_test();
	end
endmodule // tuning_controller_test
